/* File: core/vtg_defines.svh */
`ifndef VTG_DEFINES_SVH
`define VTG_DEFINES_SVH

// ==========================================================
// register offsets inside the sub-region
`define OFS_HORIZ_TIMING   16'h0030
`define OFS_VERT_TIMING    16'h0034

// ==========================================================
// field positions, shared by both timing words
`define FLD_FIRST_MSB      31
`define FLD_FIRST_LSB      22
`define FLD_RSV_HI         21
`define FLD_LAST_MSB       20
`define FLD_LAST_LSB       11
`define FLD_RSV_LO         10
`define FLD_TOTAL_MSB      9
`define FLD_TOTAL_LSB      0

// ==========================================================
// address decode of the pipeline sub-region
`define ADDR_TOP_CODE      5'h01
`define ADDR_REGION_CODE   2'h1
`define ADDR_SUBREGION     4'h2
`define ADDR_PAD_CODE      2'h0

// ==========================================================
// reset values and counter constants
`define HORIZ_RESET        32'h00000000
`define VERT_RESET         32'h00000000
`define RSV_READ_MASK      32'hFFDFFBFF
`define FIELD1_LOAD        10'h001
`define FIELD2_LOAD        10'h000
`define HCOUNT_LOAD        11'h000
`define GENLOCK_FREE       3'h0
`define WRITE_ALL_LANES    4'hF

`endif

/* File: core/vtg_pkg.sv */
package vtg_pkg;

  // ==========================================================
  // timing register word layout
  typedef struct packed
  {
    logic [9:0] first;
    logic       rsv_hi;
    logic [9:0] last;
    logic       rsv_lo;
    logic [9:0] total;
  } timing_word_s;

  // ==========================================================
  // host cpu access
  typedef struct packed
  {
    logic [31:0] addr;
    logic        wr;
    logic        rd;
    logic [3:0]  be;
    logic [31:0] wdata;
  } host_req_s;

  // ==========================================================
  // generator state
  typedef enum logic [1:0]
  {
    ST_HELD = 2'b01,
    ST_RUN  = 2'b10
  } timing_state_e;

endpackage

/* File: core/hv_counter.sv */
`timescale 1ns/100ps
module hv_counter #(
  parameter int          W         = 11,
  parameter logic [W-1:0] RESET_VAL = '0
)(
  input  wire logic         clk_sys_i,
  input  wire logic         reset_n_i,
  input  wire logic         ce_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  input  wire logic         inc_i,
  output logic      [W-1:0] count_o
);

  logic [W-1:0] next_count;

  // ==========================================================
  // load beats increment
  always_comb
  begin
    next_count = count_o;
    if (load_i)
    begin
      next_count = load_val_i;
    end
    else if (inc_i)
    begin
      next_count = count_o + W'(1);
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      count_o <= RESET_VAL;
    end
    else if (ce_i)
    begin
      count_o <= next_count;
    end
  end

endmodule

/* File: core/window_compare.sv */
`timescale 1ns/100ps
module window_compare #(
  parameter int W = 11
)(
  input  wire logic [W-1:0] value_i,
  input  wire logic [W-1:0] low_i,
  input  wire logic [W-1:0] high_i,
  output logic              inside_o
);

  // ==========================================================
  // inclusive on both ends
  assign inside_o = (value_i >= low_i) && (value_i <= high_i);

endmodule

/* File: core/video_hv_timing_generator.sv */
// Notes on behaviour
// - active video starts at horizontal bits 31-22 pixel position
// - active video ends at horizontal bits 20-11 pixel position
// - when selected, capture accepted only inside horizontal and vertical window
// - horizontal bits 9-0 give total pixel positions per line
// - vertical bits 31-22 name last blanked line; active begins next line
// - vertical bits 20-11 name last active line of each field
// - line counter restarts on reaching vertical bits 9-0
// - field 1 loads line count one, field 2 loads zero
// - field flag toggles with the counter reset at field start
// - reserved bits 21 and 10 read-only, value unspecified
// - reads of any width: byte, word or double word
// - registers decoded in 256-KByte sub-region 2 of 4-MByte area
// - pixel positions doubled, odd compensation bit appended as lsb
// - enable clear holds timing at start of field 1
// - genlock off: counters reset themselves from line and field totals
`timescale 1ns/100ps
`include "vtg_defines.svh"
module video_hv_timing_generator (
  input  wire logic              clk_sys_i,
  input  wire logic              reset_n_i,
  input  wire logic              ce_i,
  input  wire vtg_pkg::host_req_s host_req_i,
  input  wire logic [2:0]        gbase_i,
  input  wire logic              timing_enable_i,
  input  wire logic [2:0]        genlock_mode_i,
  input  wire logic              odd_comp_i,
  input  wire logic              capture_sel_i,
  output logic      [31:0]       host_rdata_o,
  output logic                   host_ack_o,
  output logic      [10:0]       hcount_o,
  output logic      [9:0]        vcount_o,
  output logic                   field_o,
  output logic                   field_start_o,
  output logic                   capture_accept_o
);
  import vtg_pkg::*;

  // ==========================================================
  // declarations
  timing_word_s  horiz_timing;
  timing_word_s  vert_timing;
  timing_word_s  next_horiz_timing;
  timing_word_s  next_vert_timing;
  logic [31:0]   next_host_rdata;
  logic          next_host_ack;
  logic          region_hit;
  logic [15:0]   word_offset;
  logic          write_ok;
  logic [31:0]   read_word;
  logic [31:0]   lane_mask;

  timing_state_e state;
  timing_state_e next_state;
  logic          running;
  logic          held;
  logic          field_flag;
  logic          next_field_flag;
  logic          next_field_start;
  logic          next_capture_accept;

  logic [11:0]   line_clocks;
  logic [11:0]   hcount_plus;
  logic          line_wrap;
  logic          field_wrap;
  logic          h_load;
  logic          v_load;
  logic          v_inc;
  logic [9:0]    v_load_val;

  logic [10:0]   h_low;
  logic [10:0]   h_high;
  logic [10:0]   v_low;
  logic [10:0]   v_high;
  logic [10:0]   v_value;
  logic          h_inside;
  logic          v_inside;

  // ==========================================================
  // host decode
  assign region_hit = (host_req_i.addr[31:27] == `ADDR_TOP_CODE)
                   && (host_req_i.addr[26:24] == gbase_i)
                   && (host_req_i.addr[23:22] == `ADDR_REGION_CODE)
                   && (host_req_i.addr[21:18] == `ADDR_SUBREGION)
                   && (host_req_i.addr[17:16] == `ADDR_PAD_CODE);
  assign word_offset = {host_req_i.addr[15:2], 2'b00};
  // narrow writes dropped whole rather than merged
  assign write_ok = host_req_i.wr && region_hit
                 && (host_req_i.be == `WRITE_ALL_LANES);

  // ==========================================================
  // register file
  always_comb
  begin
    next_horiz_timing = horiz_timing;
    next_vert_timing  = vert_timing;
    if (write_ok)
    begin
      case (word_offset)
        `OFS_HORIZ_TIMING:
        begin
          next_horiz_timing = host_req_i.wdata & `RSV_READ_MASK;
        end
        `OFS_VERT_TIMING:
        begin
          next_vert_timing = host_req_i.wdata & `RSV_READ_MASK;
        end
        default:
        begin
          next_horiz_timing = horiz_timing;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      horiz_timing <= `HORIZ_RESET;
      vert_timing  <= `VERT_RESET;
    end
    else if (ce_i)
    begin
      horiz_timing <= next_horiz_timing;
      vert_timing  <= next_vert_timing;
    end
  end

  // ==========================================================
  // read path
  always_comb
  begin
    case (word_offset)
      `OFS_HORIZ_TIMING: read_word = horiz_timing;
      `OFS_VERT_TIMING:  read_word = vert_timing;
      default:           read_word = 32'h00000000;
    endcase
  end

  // unselected lanes read zero so any width sees its bytes in place
  assign lane_mask = {{8{host_req_i.be[3]}}, {8{host_req_i.be[2]}},
                      {8{host_req_i.be[1]}}, {8{host_req_i.be[0]}}};

  always_comb
  begin
    next_host_ack   = 1'b0;
    next_host_rdata = host_rdata_o;
    if (host_req_i.rd && region_hit)
    begin
      next_host_ack   = 1'b1;
      next_host_rdata = read_word & lane_mask;
    end
    else if (write_ok)
    begin
      next_host_ack = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      host_rdata_o <= 32'h00000000;
      host_ack_o   <= 1'b0;
    end
    else if (ce_i)
    begin
      host_rdata_o <= next_host_rdata;
      host_ack_o   <= next_host_ack;
    end
  end

  // ==========================================================
  // run control
  always_comb
  begin
    case (state)
      ST_HELD:
      begin
        // other genlock modes need sync inputs this block lacks
        if (timing_enable_i && (genlock_mode_i == `GENLOCK_FREE))
        begin
          next_state = ST_RUN;
        end
        else
        begin
          next_state = ST_HELD;
        end
      end
      ST_RUN:
      begin
        if (!timing_enable_i || (genlock_mode_i != `GENLOCK_FREE))
        begin
          next_state = ST_HELD;
        end
        else
        begin
          next_state = ST_RUN;
        end
      end
      default:
      begin
        next_state = ST_HELD;
      end
    endcase
  end

  assign running = (state == ST_RUN);
  assign held    = !running;

  // ==========================================================
  // counter control
  // counter runs at twice the pixel rate
  assign line_clocks = {1'b0, horiz_timing.total, 1'b0};
  assign hcount_plus = {1'b0, hcount_o} + 12'h001;
  // >= keeps a shrunk total from running the count away
  assign line_wrap   = running && (hcount_plus >= line_clocks);
  assign field_wrap  = line_wrap && (vcount_o >= vert_timing.total);

  assign h_load = held || line_wrap;
  assign v_load = held || field_wrap;
  assign v_inc  = line_wrap && !field_wrap;

  always_comb
  begin
    if (held)
    begin
      v_load_val = `FIELD1_LOAD;
    end
    else if (field_flag)
    begin
      v_load_val = `FIELD1_LOAD;
    end
    else
    begin
      v_load_val = `FIELD2_LOAD;
    end
  end

  always_comb
  begin
    next_field_flag = field_flag;
    if (held)
    begin
      next_field_flag = 1'b0;
    end
    else if (field_wrap)
    begin
      next_field_flag = !field_flag;
    end
  end

  hv_counter #(
    .W         (11),
    .RESET_VAL (`HCOUNT_LOAD)
  ) u_hcount (
    .clk_sys_i  (clk_sys_i),
    .reset_n_i  (reset_n_i),
    .ce_i       (ce_i),
    .load_i     (h_load),
    .load_val_i (`HCOUNT_LOAD),
    .inc_i      (running),
    .count_o    (hcount_o)
  );

  hv_counter #(
    .W         (10),
    .RESET_VAL (`FIELD1_LOAD)
  ) u_vcount (
    .clk_sys_i  (clk_sys_i),
    .reset_n_i  (reset_n_i),
    .ce_i       (ce_i),
    .load_i     (v_load),
    .load_val_i (v_load_val),
    .inc_i      (v_inc),
    .count_o    (vcount_o)
  );

  // ==========================================================
  // active window
  assign h_low   = {horiz_timing.first, odd_comp_i};
  assign h_high  = {horiz_timing.last, odd_comp_i};
  assign v_low   = {1'b0, vert_timing.first} + 11'h001;
  assign v_high  = {1'b0, vert_timing.last};
  assign v_value = {1'b0, vcount_o};

  window_compare #(
    .W (11)
  ) u_hwin (
    .value_i  (hcount_o),
    .low_i    (h_low),
    .high_i   (h_high),
    .inside_o (h_inside)
  );

  window_compare #(
    .W (11)
  ) u_vwin (
    .value_i  (v_value),
    .low_i    (v_low),
    .high_i   (v_high),
    .inside_o (v_inside)
  );

  // accept lags the counters by one cycle
  assign next_capture_accept = running && capture_sel_i
                            && h_inside && v_inside;
  assign next_field_start = field_wrap;

  // ==========================================================
  // state and outputs
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      state            <= ST_HELD;
      field_flag       <= 1'b0;
      field_start_o    <= 1'b0;
      capture_accept_o <= 1'b0;
    end
    else if (ce_i)
    begin
      state            <= next_state;
      field_flag       <= next_field_flag;
      field_start_o    <= next_field_start;
      capture_accept_o <= next_capture_accept;
    end
  end

  assign field_o = field_flag;

endmodule

/* File: test/vtg_monitor.sv */
`timescale 1ns/100ps
// ==========================================================
// port checks
module vtg_monitor (
  input wire logic               clk_sys_i,
  input wire logic               reset_n_i,
  input wire logic               ce_i,
  input wire vtg_pkg::host_req_s host_req_i,
  input wire logic [2:0]         gbase_i,
  input wire logic               timing_enable_i,
  input wire logic [2:0]         genlock_mode_i,
  input wire logic               odd_comp_i,
  input wire logic               capture_sel_i,
  input wire logic [31:0]        host_rdata_o,
  input wire logic               host_ack_o,
  input wire logic [10:0]        hcount_o,
  input wire logic [9:0]         vcount_o,
  input wire logic               field_o,
  input wire logic               field_start_o,
  input wire logic               capture_accept_o
);
  import vtg_pkg::*;
  logic        hit;
  logic        take;
  logic [31:0] lanes;
  assign hit = host_req_i.addr[31:27] == 5'h01 && host_req_i.addr[26:24] == gbase_i
    && host_req_i.addr[23:16] == 8'h48;
  assign take = ce_i && hit && (host_req_i.rd || (host_req_i.wr && host_req_i.be == 4'hF));
  assign lanes = {{8{host_req_i.be[3]}}, {8{host_req_i.be[2]}},
    {8{host_req_i.be[1]}}, {8{host_req_i.be[0]}}};
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  a_ack_after_take:
    assert property (take |=> host_ack_o) else $error("no ack after access");
  a_ack_needs_take:
    assert property (host_ack_o |-> $past(take)) else $error("ack without access");
  a_narrow_wr_refused:
    assert property (host_req_i.wr && !host_req_i.rd && host_req_i.be != 4'hF |=> !host_ack_o)
    else $error("narrow write acked");
  a_read_lane_mask:
    assert property (host_ack_o && $past(host_req_i.rd)
      |-> (host_rdata_o & ~$past(lanes)) == 32'h0)
    else $error("unselected lane not zero");
  a_rsv_read_zero:
    assert property (host_ack_o && $past(host_req_i.rd)
      |-> !host_rdata_o[21] && !host_rdata_o[10])
    else $error("reserved bit set");
  a_hold_enable_low:
    assert property (!timing_enable_i
      |-> ##2 (hcount_o == 11'h000 && vcount_o == 10'h001 && !field_o))
    else $error("timing not held");
  a_hold_genlock_on:
    assert property (genlock_mode_i != 3'h0 |-> ##2 (hcount_o == 11'h000 && !capture_accept_o))
    else $error("genlock mode not held");
  a_hcount_step:
    assert property ($changed(hcount_o) && hcount_o != 11'h000
      |-> hcount_o == $past(hcount_o) + 11'h001)
    else $error("horizontal step wrong");
  a_vcount_on_wrap:
    assert property ($changed(vcount_o) |-> hcount_o == 11'h000
      && (vcount_o == $past(vcount_o) + 10'h001 || vcount_o <= 10'h001))
    else $error("line count step wrong");
  a_field_flip_load:
    assert property ($changed(field_o) |-> hcount_o == 11'h000 && vcount_o == {9'h000, ~field_o})
    else $error("field flip not at restart");
  a_field_start_pulse:
    // the pulse is registered on the same edge that flips the field
    assert property ($rose(field_o) |-> field_start_o) else $error("no field start pulse");
  a_accept_needs_sel:
    assert property (capture_accept_o |-> $past(capture_sel_i) && $past(vcount_o) != 10'h000)
    else $error("accept outside window");
endmodule

bind video_hv_timing_generator vtg_monitor u_mon (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .host_req_i(host_req_i),
  .gbase_i(gbase_i), .timing_enable_i(timing_enable_i), .genlock_mode_i(genlock_mode_i),
  .odd_comp_i(odd_comp_i), .capture_sel_i(capture_sel_i), .host_rdata_o(host_rdata_o),
  .host_ack_o(host_ack_o), .hcount_o(hcount_o), .vcount_o(vcount_o), .field_o(field_o),
  .field_start_o(field_start_o), .capture_accept_o(capture_accept_o));

/* File: test/host_cpu.sv */
`timescale 1ns/100ps
// ==========================================================
// host cpu, one access at a time
module host_cpu (
  input  wire logic        clk_sys_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] rdata_i,
  output vtg_pkg::host_req_s req_o
);
  import vtg_pkg::*;
  initial req_o = '0;
  // be other than 1111 on a write only when a test asks for a refusal
  task automatic xfer(input logic rd, input logic wr, input logic [2:0] gb,
    input logic [15:0] ofs, input logic [3:0] be, input logic [31:0] wd,
    output logic ack, output logic [31:0] dat);
    @(posedge clk_sys_i);
    req_o <= '{addr: {5'h01, gb, 8'h48, ofs}, wr: wr, rd: rd, be: be, wdata: wd};
    @(posedge clk_sys_i);
    // released lines show the inverse, not the last value
    req_o <= '{addr: ~req_o.addr, wr: 1'b0, rd: 1'b0, be: ~req_o.be, wdata: ~req_o.wdata};
    // answer launched at the taking edge, read at the next one
    @(posedge clk_sys_i);
    ack = ack_i;
    dat = rdata_i;
  endtask
endmodule

/* File: test/tb.sv */
`timescale 1ns/100ps
// ==========================================================
// bench
module tb;
  import vtg_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        timing_enable_i = 1'b0;
  logic        odd_comp_i = 1'b0;
  logic        capture_sel_i = 1'b1;
  logic [2:0]  gbase_i = 3'h5;
  logic [2:0]  genlock_mode_i = 3'h0;
  host_req_s   host_req_i;
  logic [31:0] host_rdata_o;
  logic        host_ack_o;
  logic [10:0] hcount_o;
  logic [9:0]  vcount_o;
  logic        field_o;
  logic        field_start_o;
  logic        capture_accept_o;
  int          n_fail = 0;
  int          comparisons = 0;
  int          cycles = 0;
  logic        ack;
  logic [31:0] dat;

  always #25 clk_sys_i = ~clk_sys_i;

  host_cpu host (.clk_sys_i(clk_sys_i), .ack_i(host_ack_o), .rdata_i(host_rdata_o),
    .req_o(host_req_i));

  video_hv_timing_generator dut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ce_i(1'b1), .host_req_i(host_req_i),
    .gbase_i(gbase_i), .timing_enable_i(timing_enable_i), .genlock_mode_i(genlock_mode_i),
    .odd_comp_i(odd_comp_i), .capture_sel_i(capture_sel_i), .host_rdata_o(host_rdata_o),
    .host_ack_o(host_ack_o), .hcount_o(hcount_o), .vcount_o(vcount_o), .field_o(field_o),
    .field_start_o(field_start_o), .capture_accept_o(capture_accept_o));

  task automatic print_verdict();
    if (n_fail == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_int(input int got, input int exp, input string what);
    comparisons++;
    if (got != exp)
    begin
      n_fail++;
      $display("ERROR %0t %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  task automatic rd(input logic [15:0] ofs, input logic [3:0] be, input logic [31:0] exp);
    host.xfer(1'b1, 1'b0, gbase_i, ofs, be, 32'h0, ack, dat);
    check_word({31'h0, ack}, 32'h1, "read ack");
    check_word(dat, exp, "read data");
  endtask

  task automatic wr(input logic [15:0] ofs, input logic [3:0] be, input logic [31:0] wd,
    input logic exp_ack);
    host.xfer(1'b0, 1'b1, gbase_i, ofs, be, wd, ack, dat);
    check_word({31'h0, ack}, {31'h0, exp_ack}, "write ack");
  endtask

  // one field, start pulse to start pulse: length, accepted cycles, first accepted hcount
  task automatic measure(input int len, input int acc, input logic [10:0] first_h);
    int          n;
    int          a;
    logic [10:0] ph;
    logic [10:0] fh;
    n = 0;
    // reads at an edge see what the edge before launched
    while (field_start_o !== 1'b1 && n < 300)
    begin
      @(posedge clk_sys_i);
      n++;
    end
    n = 0;
    a = 0;
    fh = 11'h7FF;
    do
    begin
      ph = hcount_o;
      @(posedge clk_sys_i);
      n++;
      if (capture_accept_o === 1'b1)
      begin
        if (a == 0)
          fh = ph;
        a++;
      end
    end while (field_start_o !== 1'b1 && n < 300);
    check_int(n, len, "field length");
    check_int(a, acc, "accepted cycles");
    if (acc > 0)
      check_word({21'h0, fh}, {21'h0, first_h}, "window start");
  endtask

  task automatic check_held();
    repeat (3) @(posedge clk_sys_i);
    check_word({10'h000, field_o, vcount_o, hcount_o}, {10'h000, 1'b0, 10'h001, 11'h000},
      "held state");
  endtask

  // ==========================================================
  // hang guard, about ten times the expected run
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    rd(16'h0030, 4'hF, 32'h00000000);
    rd(16'h0034, 4'hF, 32'h00000000);
    wr(16'h0030, 4'hF, 32'h00601C04, 1'b1);
    wr(16'h0034, 4'hF, 32'h00601403, 1'b1);
    rd(16'h0030, 4'hF, 32'h00401804);
    rd(16'h0034, 4'hF, 32'h00401003);
    rd(16'h0030, 4'h2, 32'h00001800);
    rd(16'h0030, 4'hC, 32'h00400000);
    wr(16'h0034, 4'h3, 32'h00000000, 1'b0);
    rd(16'h0034, 4'hF, 32'h00401003);
    rd(16'h0038, 4'hF, 32'h00000000);
    host.xfer(1'b1, 1'b0, 3'h2, 16'h0030, 4'hF, 32'h0, ack, dat);
    check_word({31'h0, ack}, 32'h0, "foreign region ack");
    timing_enable_i <= 1'b1;
    // leaving the held state gives no start pulse, so field 2 is measured first
    measure(32, 5, 11'h002);
    measure(24, 5, 11'h002);
    check_word({31'h0, field_o}, 32'h1, "second field flag");
    odd_comp_i <= 1'b1;
    measure(32, 5, 11'h003);
    capture_sel_i <= 1'b0;
    measure(24, 0, 11'h000);
    timing_enable_i <= 1'b0;
    check_held();
    timing_enable_i <= 1'b1;
    for (int g = 1; g < 8; g++)
    begin
      genlock_mode_i <= 3'(g);
      check_held();
    end
    genlock_mode_i <= 3'h0;
    capture_sel_i <= 1'b1;
    measure(32, 5, 11'h003);
    reset_n_i <= 1'b0;
    check_held();
    reset_n_i <= 1'b1;
    rd(16'h0030, 4'hF, 32'h00000000);
    print_verdict();
  end
endmodule
